/* verilog/scc_top.sv */
/*
  Smart card channel: Wishbone registers, card clock pin, convention
  handling and frame engine on one open-drain data line.
  Assumes an external pull-up on the data line and on the clock pin.
*/
// Design decisions made here: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
`include "scc_regs.svh"
module scc_top (
  input wire logic CLK, // 100 MHz clock
  input wire logic RESET_N, // Sync reset, active low
  input scc_pkg::scc_wb_req_t WB_REQ, // Wishbone request
  output logic [31:0] WB_DAT_O, // Read data
  output logic WB_ACK_O, // Wishbone ack
  input wire logic DATA_I, // Data line level
  output logic DATA_O, // Data drive value, always low
  output logic DATA_OE, // Pull data line low
  input wire logic SCK_I, // Clock pin level
  output logic SCK_O, // Clock pin value
  output logic SCK_OE // Clock pin drive enable
);
  import scc_pkg::*;
  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  // Register index from byte address, 4'hF when unmapped
  function automatic logic [3:0] reg_idx(input logic [7:0] adr);
    reg_idx = (adr[1:0] == 2'b00 && adr <= `SCC_ADR_PORT) ? {1'b0, adr[4:2]} : 4'hF;
  endfunction : reg_idx
  // Logical data bit k taken in line order
  function automatic logic conv_bit(input logic [7:0] d, input logic [2:0] k, input logic msb1st);
    conv_bit = msb1st ? d[3'h7 - k] : d[k];
  endfunction : conv_bit
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [1:0] pin_in; // Raw pin levels
  logic [1:0] sync1_r; // First stage, read by second only
  logic [1:0] sync2_r; // Safe levels
  logic line; // Synced data line
  logic sck_pin; // Synced clock pin
  assign pin_in = {SCK_I, DATA_I};
  generate
    for (genvar g = 0; g < 2; g++) begin : g_sync
      // Two flops per pin, idle high like the pull-ups
      always_ff @(posedge CLK) begin
        if (!RESET_N) begin
          sync1_r[g] <= 1'b1;
          sync2_r[g] <= 1'b1;
        end else begin
          sync1_r[g] <= pin_in[g];
          sync2_r[g] <= sync1_r[g];
        end
      end
    end
  endgenerate
  assign line = sync2_r[0];
  assign sck_pin = sync2_r[1];
  // ----------------------------------------
  // Wishbone slave
  // ----------------------------------------
  logic req; // Live request
  logic wr_en; // Write commits at the ack edge
  logic [3:0] widx; // Decoded index
  logic [7:0] wd; // Low byte of write data
  logic [7:0] rd_byte; // Read mux
  assign req = WB_REQ.cyc && WB_REQ.stb;
  assign widx = reg_idx(WB_REQ.adr);
  assign wr_en = req && WB_ACK_O && WB_REQ.we && WB_REQ.sel[0];
  assign wd = WB_REQ.dat[7:0];
  // Ack one cycle after the request, dropped the cycle after
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h00000000;
    end else begin
      WB_ACK_O <= req && !WB_ACK_O;
      if (req && !WB_ACK_O) begin
        WB_DAT_O <= {24'h000000, rd_byte};
      end
    end
  end
  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  logic [7:0] mode_r; // serial_mode_setting
  logic [7:0] brr_r; // bit_rate_divisor
  logic [7:0] ctrl_r; // serial_control
  logic [7:0] tdr_r; // transmit_holding
  logic [7:0] rdr_r; // receive_holding
  logic [7:0] cmr_r; // card_mode_control
  logic [1:0] port_r; // clock_port_direction, clock_port_value
  logic timing_select; // End flag and clock level mode
  logic parity_odd; // Parity sense
  logic transmit_enable; // Transmitter on
  logic receive_enable; // Receiver on
  logic card_mode_enable; // Channel active
  logic bit_order_select; // MSB first
  logic data_invert_select; // Invert data bits
  assign timing_select = mode_r[`SCC_MODE_TSEL];
  assign parity_odd = mode_r[`SCC_MODE_ODD];
  assign transmit_enable = ctrl_r[`SCC_CTRL_TE];
  assign receive_enable = ctrl_r[`SCC_CTRL_RE];
  assign card_mode_enable = cmr_r[`SCC_CMR_CARD_MODE_ENABLE];
  assign bit_order_select = cmr_r[`SCC_CMR_BIT_ORDER_SELECT];
  assign data_invert_select = cmr_r[`SCC_CMR_DATA_INVERT_SELECT];
  // Fixed-value mode bits are stored as written; software keeps them right
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      mode_r <= 8'h00;
      brr_r <= `SCC_RST_BRR;
      ctrl_r <= 8'h00;
      tdr_r <= `SCC_RST_TDR;
      cmr_r <= 8'h00;
      port_r <= 2'b00;
    end else if (wr_en) begin
      case (widx)
        4'h0: mode_r <= wd;
        4'h1: brr_r <= wd;
        4'h2: ctrl_r <= wd;
        4'h3: tdr_r <= wd;
        4'h6: cmr_r <= wd & 8'h0D;
        4'h7: port_r <= wd[3:2];
        default: ;
      endcase
    end
  end
  // ----------------------------------------
  // Card clock and etu timing
  // ----------------------------------------
  logic card_phase; // Generated card clock
  logic card_rise; // Card clock rising edge
  scc_clkgen u_clkgen (
    .clk(CLK),
    .reset_n(RESET_N),
    .cks(mode_r[1:0]),
    .brr(brr_r),
    .phase(card_phase),
    .rise(card_rise)
  );
  scc_state_t state_r; // Frame engine state
  logic [7:0] cc_r; // Card clocks in this half etu
  logic [4:0] half_r; // Half etu since start bit
  logic [4:0] h_nxt; // Half etu about to begin
  logic half_tick; // Half etu boundary
  logic err_r; // Error signal seen this frame
  logic restart; // Retransmit begins
  assign half_tick = card_rise && (cc_r == `SCC_HALF_ETU_LAST);
  assign h_nxt = half_r + 5'h01;
  assign restart = (state_r == ST_TX) && err_r && half_tick && (h_nxt == `SCC_H_RETRY);
  // Bit time counted only from card clocks, never an outside clock
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      cc_r <= 8'h00;
      half_r <= 5'h00;
    end else if (state_r == ST_IDLE || restart) begin
      cc_r <= 8'h00;
      half_r <= 5'h00;
    end else if (card_rise) begin
      cc_r <= half_tick ? 8'h00 : cc_r + 8'h01;
      if (half_tick) begin
        half_r <= h_nxt;
      end
    end
  end
  // ----------------------------------------
  // Transmit bit on the line
  // ----------------------------------------
  logic [7:0] tx_byte_r; // Character being sent
  logic tx_bit; // Line value of current bit
  logic [3:0] bit_k; // Bit slot, 0 is start, 9 is parity
  assign bit_k = half_r[4:1];
  // Data bits inverted by convention, parity sense carries the rest
  always_comb begin
    tx_bit = 1'b1;
    if (bit_k == 4'h0) begin
      tx_bit = 1'b0;
    end else if (bit_k <= 4'h8) begin
      tx_bit = conv_bit(tx_byte_r, 3'(bit_k - 4'h1), bit_order_select) ^ data_invert_select;
    end else if (bit_k == 4'h9) begin
      tx_bit = ^tx_byte_r ^ parity_odd;
    end
  end
  // ----------------------------------------
  // Frame engine
  // ----------------------------------------
  logic [7:0] rx_byte_r; // Character being received
  logic par_err_r; // Parity failed on this frame
  logic tx_done; // Character accepted by card
  logic err_now; // Error signal at sample point
  logic rx_store; // Receive character complete
  logic rx_par_bad; // Parity check result
  logic transmit_empty_flag_r; // transmit_empty_flag
  assign err_now = (state_r == ST_TX) && half_tick && (h_nxt == `SCC_H_ERR_SMP) && !line;
  assign tx_done = (state_r == ST_TX) && half_tick && !err_r && !err_now
    && (h_nxt == (timing_select ? `SCC_H_TEND1 : `SCC_H_TEND0));
  assign rx_par_bad = (^rx_byte_r ^ line ^ parity_odd) != 1'b0;
  assign rx_store = (state_r == ST_RX) && half_tick && (h_nxt == `SCC_H_PARITY);
  // Whole engine halts while card mode is off
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      state_r <= ST_IDLE;
      tx_byte_r <= 8'h00;
      rx_byte_r <= 8'h00;
      err_r <= 1'b0;
      par_err_r <= 1'b0;
    end else if (!card_mode_enable) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE: begin
          err_r <= 1'b0;
          par_err_r <= 1'b0;
          if (transmit_enable && !transmit_empty_flag_r) begin
            state_r <= ST_TX;
            tx_byte_r <= tdr_r;
          end else if (receive_enable && !line) begin
            state_r <= ST_RX;
          end
        end
        ST_TX: begin
          // Sample the error signal mid-pulse, then end or resend
          if (err_now) begin
            err_r <= 1'b1;
          end
          if (!transmit_enable || tx_done) begin
            state_r <= ST_IDLE;
          end else if (restart) begin
            err_r <= 1'b0;
          end
        end
        ST_RX: begin
          if (half_tick && h_nxt[0] && h_nxt >= 5'h03 && h_nxt <= 5'h11) begin
            rx_byte_r[bit_order_select ? 3'(5'h08 - h_nxt[4:1]) : 3'(h_nxt[4:1] - 5'h01)]
              <= line ^ data_invert_select;
          end
          if (half_tick && h_nxt == 5'h01 && line) begin
            state_r <= ST_IDLE; // Glitch, not a start bit
          end
          if (rx_store) begin
            par_err_r <= rx_par_bad;
          end
          if (!receive_enable || (half_tick && h_nxt == `SCC_H_RX_DONE && !par_err_r)
              || (half_tick && h_nxt == `SCC_H_ERR_OFF)) begin
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end
  // ----------------------------------------
  // Status flags, set wins over software clear
  // ----------------------------------------
  logic receive_full_flag_r; // receive_full_flag
  logic orer_r; // Overrun
  logic ers_r; // error_signal_flag
  logic per_r; // Parity error
  logic transmit_end_flag_r; // transmit_end_flag
  logic stat_wr; // Status write strobe
  assign stat_wr = wr_en && widx == 4'h4;
  // Zero written to a flag clears it; clearing empty also clears end
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      transmit_empty_flag_r <= 1'b1;
      receive_full_flag_r <= 1'b0;
      orer_r <= 1'b0;
      ers_r <= 1'b0;
      per_r <= 1'b0;
      transmit_end_flag_r <= 1'b1;
    end else begin
      transmit_empty_flag_r <= tx_done || (transmit_empty_flag_r && !(stat_wr && !wd[7]));
      transmit_end_flag_r <= tx_done || (!transmit_enable && !ers_r) || (transmit_end_flag_r && !(stat_wr && !wd[7]));
      receive_full_flag_r <= (rx_store && !receive_full_flag_r) || (receive_full_flag_r && !(stat_wr && !wd[6]));
      orer_r <= (rx_store && receive_full_flag_r) || (orer_r && !(stat_wr && !wd[5]));
      ers_r <= err_now || (ers_r && !(stat_wr && !wd[4]));
      per_r <= (rx_store && rx_par_bad) || (per_r && !(stat_wr && !wd[3]));
    end
  end
  // Received data kept even on parity error, lost on overrun
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      rdr_r <= 8'h00;
    end else if (rx_store && !receive_full_flag_r) begin
      rdr_r <= rx_byte_r;
    end
  end
  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  always_comb begin
    case (widx)
      4'h0: rd_byte = mode_r;
      4'h1: rd_byte = brr_r;
      4'h2: rd_byte = ctrl_r;
      4'h3: rd_byte = tdr_r;
      4'h4: rd_byte = {transmit_empty_flag_r, receive_full_flag_r, orer_r, ers_r, per_r, transmit_end_flag_r, 2'b00};
      4'h5: rd_byte = rdr_r;
      4'h6: rd_byte = cmr_r;
      4'h7: rd_byte = {4'h0, port_r[1], port_r[1] ? port_r[0] : sck_pin, 2'b00};
      default: rd_byte = 8'h00;
    endcase
  end
  // ----------------------------------------
  // Data line drive
  // ----------------------------------------
  // Open drain: only ever pulls low, idle release lets the pull-up win
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      DATA_OE <= 1'b0;
      DATA_O <= 1'b0;
    end else begin
      DATA_O <= 1'b0;
      DATA_OE <= card_mode_enable && (((state_r == ST_TX) && half_r < `SCC_H_TX_REL && !tx_bit)
        || ((state_r == ST_RX) && par_err_r && half_r > `SCC_H_RX_DONE));
    end
  end
  // ----------------------------------------
  // Card clock pin
  // ----------------------------------------
  // Clock enable wins while card mode is on; level mode only with timing select
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      SCK_O <= 1'b0;
      SCK_OE <= 1'b0;
    end else if (card_mode_enable && ctrl_r[`SCC_CTRL_CKOE]) begin
      SCK_O <= card_phase;
      SCK_OE <= 1'b1;
    end else if (card_mode_enable && timing_select) begin
      SCK_O <= ctrl_r[`SCC_CTRL_CKLVL];
      SCK_OE <= 1'b1;
    end else begin
      SCK_O <= port_r[0];
      SCK_OE <= port_r[1];
    end
  end
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_port_pin_mode: assert property (@(posedge CLK) disable iff (!RESET_N)
    (card_mode_enable && !timing_select && ctrl_r[1:0] == 2'b00)
      |=> (SCK_OE == $past(port_r[1])) && (SCK_O == $past(port_r[0])))
    else $error("clock pin not in port mode");
  chk_fixed_level: assert property (@(posedge CLK) disable iff (!RESET_N)
    (card_mode_enable && timing_select && !ctrl_r[0]) |=> SCK_OE && (SCK_O == $past(ctrl_r[1])))
    else $error("clock pin level wrong");
  chk_clock_out: assert property (@(posedge CLK) disable iff (!RESET_N)
    (card_mode_enable && ctrl_r[0]) |=> SCK_OE && (SCK_O == $past(card_phase)))
    else $error("clock pin not driving clock");
  chk_mode_gate: assert property (@(posedge CLK) disable iff (!RESET_N)
    !card_mode_enable |=> state_r == ST_IDLE) else $error("engine active outside card mode");
  chk_line_release: assert property (@(posedge CLK) disable iff (!RESET_N)
    !card_mode_enable ##1 !card_mode_enable |-> !DATA_OE) else $error("data line driven while off");
  chk_transmit_end_flag_point: assert property (@(posedge CLK) disable iff (!RESET_N)
    tx_done |-> ((h_nxt == (timing_select ? 5'h16 : 5'h19)) && !err_r) ##1 (transmit_end_flag_r && transmit_empty_flag_r))
    else $error("end flag at wrong etu");
  chk_error_pulse: assert property (@(posedge CLK) disable iff (!RESET_N)
    (state_r == ST_RX && par_err_r && half_tick && h_nxt == 5'h15 && card_mode_enable)
      |-> ##2 DATA_OE) else $error("no error signal after parity error");
  chk_retry_start: assert property (@(posedge CLK) disable iff (!RESET_N)
    (restart && transmit_enable && card_mode_enable) |=> (state_r == ST_TX) && (half_r == 5'h00))
    else $error("resend did not restart frame");
  chk_etu_lock: assert property (@(posedge CLK) disable iff (!RESET_N)
    (state_r != ST_IDLE && half_r != 5'h00 && $changed(half_r)) |-> $past(card_rise))
    else $error("bit time moved without card clock");
endmodule : scc_top

/* verilog/scc_regs.svh */
/*
  Register offsets, field positions, reset values and etu timing points
  for the smart card channel. Assumes an 8-bit Wishbone byte address.
*/
`ifndef SCC_REGS_SVH
`define SCC_REGS_SVH
// ----------------------------------------
// Offsets
// ----------------------------------------
`define SCC_ADR_MODE 8'h00
`define SCC_ADR_BRR 8'h04
`define SCC_ADR_CTRL 8'h08
`define SCC_ADR_TDR 8'h0C
`define SCC_ADR_STAT 8'h10
`define SCC_ADR_RDR 8'h14
`define SCC_ADR_CMR 8'h18
`define SCC_ADR_PORT 8'h1C
// ----------------------------------------
// Field positions
// ----------------------------------------
`define SCC_MODE_TSEL 7
`define SCC_MODE_ODD 4
`define SCC_CTRL_TE 5
`define SCC_CTRL_RE 4
`define SCC_CTRL_CKLVL 1
`define SCC_CTRL_CKOE 0
`define SCC_CMR_BIT_ORDER_SELECT 3
`define SCC_CMR_DATA_INVERT_SELECT 2
`define SCC_CMR_CARD_MODE_ENABLE 0
`define SCC_PORT_DIR 3
`define SCC_PORT_VAL 2
// ----------------------------------------
// Reset values
// ----------------------------------------
`define SCC_RST_BRR 8'hFF
`define SCC_RST_TDR 8'hFF
// ----------------------------------------
// Timing, in card clocks and half etu
// ----------------------------------------
`define SCC_ETU_CARD_CLKS 372
`define SCC_HALF_ETU_LAST 8'(`SCC_ETU_CARD_CLKS / 2 - 1)
`define SCC_H_TX_REL 5'h14
`define SCC_H_ERR_SMP 5'h16
`define SCC_H_RETRY 5'h18
`define SCC_H_TEND0 5'h19
`define SCC_H_TEND1 5'h16
`define SCC_H_PARITY 5'h13
`define SCC_H_RX_DONE 5'h14
`define SCC_H_ERR_OFF 5'h17
`endif

/* verilog/scc_pkg.sv */
/*
  Types of the smart card channel. Assumes scc_regs.svh for constants.
*/
package scc_pkg;
  // Wishbone request from the master
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } scc_wb_req_t;
  // Frame engine states
  typedef enum logic [1:0] {ST_IDLE, ST_TX, ST_RX} scc_state_t;
endpackage : scc_pkg

/* verilog/scc_clkgen.sv */
/*
  Baud generator: free running card clock of 372 times the bit rate.
  Assumes prescaler and divisor come from registers on the same clock.
*/
`timescale 1ns/1ps
module scc_clkgen (
  input wire logic clk, // Peripheral clock
  input wire logic reset_n, // Sync reset, active low
  input wire logic [1:0] cks, // Prescaler exponent n
  input wire logic [7:0] brr, // Divisor N
  output logic phase, // Card clock level
  output logic rise // One-cycle pulse at card clock rise
);
  // ----------------------------------------
  // Counters
  // ----------------------------------------
  logic [5:0] pre_r; // Prescale of 4^n
  logic [7:0] div_r; // Divisor count
  logic [5:0] pre_last; // 4^n - 1
  logic wrap; // Half period done
  assign pre_last = 6'((7'h01 << {cks, 1'b0}) - 7'h01);
  assign wrap = (pre_r >= pre_last) && (div_r >= brr);
  // Half period is 4^n*(N+1) clocks: never gated, so duty stays fixed
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pre_r <= 6'h00;
      div_r <= 8'h00;
      phase <= 1'b0;
      rise <= 1'b0;
    end else begin
      rise <= wrap && !phase;
      if (pre_r >= pre_last) begin
        pre_r <= 6'h00;
        div_r <= wrap ? 8'h00 : div_r + 8'h01;
      end else begin
        pre_r <= pre_r + 6'h01;
      end
      if (wrap) begin
        phase <= !phase;
      end
    end
  end
  // A half period of one cycle is legal at n=0, N=0, so check the restart instead
  chk_half_period: assert property (@(posedge clk) disable iff (!reset_n)
    wrap |=> (pre_r == 6'h00) && (div_r == 8'h00) && (phase != $past(phase)))
    else $error("card clock half period did not restart");
endmodule : scc_clkgen

/* bench/scc_card_model.sv */
/*
  Card model on the shared open-drain data line, timed by the card clock.
  Assumes the bench resolves the line with a pull-up and clocks this model.
*/
`timescale 1ns/1ps
module scc_card_model (
  input wire logic clk, // Peripheral clock, bounds the start wait
  input wire logic sck, // Card clock pin level
  input wire logic line, // Resolved data line level
  output logic pull // High pulls the data line low
);
  int timeouts = 0; // Start bits that never came
  initial pull = 1'b0;
  // Count card clock rises; one etu is 372 of them
  task automatic wait_sck(input int n);
    repeat (n) @(posedge sck);
  endtask : wait_sck
  // Take one frame at mid-bit; optionally answer with an error signal
  task automatic take(input logic nak, output logic [8:0] bits);
    int i;
    for (i = 0; i < 40000 && line !== 1'b0; i++) @(posedge clk);
    if (i == 40000) timeouts++;
    wait_sck(186);
    for (i = 0; i < 9; i++) begin
      wait_sck(372);
      bits[i] = line;
    end
    wait_sck(372);
    // Error signal at 10.5 etu for one etu asks for a resend
    if (nak) begin
      pull <= 1'b1;
      wait_sck(372);
      pull <= 1'b0;
      // Let the release reach the line before a following take looks for a start bit
      @(posedge clk);
    end
  endtask : take
  // Send start bit then nine raw line levels, one etu each
  task automatic give(input logic [8:0] bits);
    int i;
    pull <= 1'b1;
    wait_sck(372);
    for (i = 0; i < 9; i++) begin
      pull <= ~bits[i];
      wait_sck(372);
    end
    pull <= 1'b0; // Released, pull-up restores high
  endtask : give
endmodule : scc_card_model

/* bench/scc_top_tb.sv */
/*
  Self-checking bench for scc_top: Wishbone tasks and a card model.
  Assumes pull-ups on the data line and on the clock pin.
*/
`timescale 1ns/1ps
`include "scc_regs.svh"
module scc_top_tb;
  import scc_pkg::*;
  logic clk = 1'b0; // 100 MHz clock
  logic reset_n = 1'b0; // Sync reset, active low
  scc_wb_req_t req = '0; // Bus request
  logic [31:0] wb_dat; // Read data
  logic wb_ack; // Bus ack
  logic data_o; // Data drive value
  logic data_oe; // Data pull enable
  logic sck_o; // Clock pin value
  logic sck_oe; // Clock pin enable
  logic card_pull; // Card pulls line low
  wire line = ~((data_oe & ~data_o) | card_pull); // Open-drain, pull-up
  wire sck = sck_oe ? sck_o : 1'b1; // Pull-up when released
  int err_total = 0; // Mismatches
  int num_checks = 0; // Comparisons
  int k; // Loop index
  int p; // Measured period
  realtime t0; // Edge time
  logic [7:0] q; // Last read byte
  logic [8:0] got; // Frame seen by the card
  // Port reads back the released, pulled-up clock pin while its direction is input
  logic [7:0] rst_val [9] = '{8'h00, 8'hFF, 8'h00, 8'hFF, 8'h84, 8'h00, 8'h00, 8'h04, 8'h00};
  always #5 clk = ~clk;
  scc_top scc_top_inst (.CLK(clk), .RESET_N(reset_n), .WB_REQ(req), .WB_DAT_O(wb_dat),
    .WB_ACK_O(wb_ack), .DATA_I(line), .DATA_O(data_o), .DATA_OE(data_oe), .SCK_I(sck),
    .SCK_O(sck_o), .SCK_OE(sck_oe));
  scc_card_model scc_card_model_inst (.clk(clk), .sck(sck), .line(line), .pull(card_pull));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic print_verdict;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict
  // Classic single cycle, held until ack is sampled high
  task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d);
    int i;
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: {24'h0, d}};
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (wb_ack === 1'b1) break;
    end
    if (i == 20) begin
      err_total++;
      print_verdict;
    end
    q = wb_dat[7:0];
    req.cyc <= 1'b0;
    req.stb <= 1'b0;
    @(posedge clk);
  endtask : wb
  // Expected raw line levels of a frame, worked out from the convention
  function automatic logic [8:0] enc(input logic [7:0] d, input logic msb, input logic inv,
    input logic odd);
    logic [8:0] b;
    for (int i = 0; i < 8; i++) b[i] = (msb ? d[7 - i] : d[i]) ^ inv;
    b[8] = ^d ^ odd; // Parity is never inverted
    return b;
  endfunction : enc
  // Bounded wait for the clock pin to reach a level
  task automatic seek(input logic v);
    int i;
    for (i = 0; i < 300 && sck !== v; i++) @(posedge clk);
    if (i == 300) begin
      err_total++;
      print_verdict;
    end
  endtask : seek
  // Poll a status bit until set, within a bound
  task automatic poll(input int b);
    int i;
    for (i = 0; i < 30000; i++) begin
      wb(1'b0, `SCC_ADR_STAT, 8'h00);
      if (q[b] === 1'b1) break;
    end
    if (i == 30000) begin
      err_total++;
      print_verdict;
    end
  endtask : poll
  // Release the held character and let the card take it, twice on a nak
  task automatic xmit(input logic nak);
    fork
      begin
        scc_card_model_inst.take(nak, got);
        if (nak) scc_card_model_inst.take(1'b0, got);
      end
      wb(1'b1, `SCC_ADR_STAT, 8'h7F);
    join
    poll(2);
  endtask : xmit
  // Hang guard
  initial begin
    repeat (100000) @(posedge clk);
    err_total++;
    print_verdict;
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    // Reset values; unmapped place ignores writes and reads zero
    wb(1'b1, 8'h20, 8'h5A);
    for (k = 0; k < 9; k++) begin
      wb(1'b0, 8'(k * 4), 8'h00);
      check(q, rst_val[k]);
    end
    // Clock pin levels in level mode and port mode
    wb(1'b1, `SCC_ADR_CMR, 8'h01);
    wb(1'b1, `SCC_ADR_MODE, 8'hA8);
    repeat (3) @(posedge clk);
    check({sck_oe, sck}, 2'b10);
    wb(1'b1, `SCC_ADR_CTRL, 8'h02);
    repeat (3) @(posedge clk);
    check({sck_oe, sck}, 2'b11);
    wb(1'b1, `SCC_ADR_CTRL, 8'h00);
    wb(1'b1, `SCC_ADR_MODE, 8'h28);
    wb(1'b1, `SCC_ADR_PORT, 8'h0C);
    repeat (3) @(posedge clk);
    check({sck_oe, sck}, 2'b11);
    wb(1'b1, `SCC_ADR_PORT, 8'h08);
    repeat (3) @(posedge clk);
    check({sck_oe, sck}, 2'b10);
    wb(1'b1, `SCC_ADR_PORT, 8'h00);
    repeat (3) @(posedge clk);
    check(sck_oe, 1'b0);
    // Card clock period for prescaler and divisor, also with level set
    wb(1'b1, `SCC_ADR_BRR, 8'h01);
    for (k = 0; k < 3; k++) begin
      wb(1'b1, `SCC_ADR_MODE, (k == 2) ? 8'hA9 : 8'(8'h28 | k));
      wb(1'b1, `SCC_ADR_CTRL, (k == 2) ? 8'h03 : 8'h01);
      seek(1'b0);
      seek(1'b1);
      t0 = $realtime;
      seek(1'b0);
      seek(1'b1);
      p = int'(($realtime - t0) / 10.0);
      check(p, (k == 0) ? 4 : 16);
    end
    // Direct convention character
    wb(1'b1, `SCC_ADR_BRR, 8'h00);
    wb(1'b1, `SCC_ADR_MODE, 8'h28);
    wb(1'b1, `SCC_ADR_CTRL, 8'h01);
    wb(1'b1, `SCC_ADR_TDR, 8'h3B);
    wb(1'b1, `SCC_ADR_CTRL, 8'h21);
    xmit(1'b0);
    check(got, enc(8'h3B, 1'b0, 1'b0, 1'b0));
    check(got[8], 1'b1);
    // Inverse convention character
    wb(1'b1, `SCC_ADR_CTRL, 8'h01);
    wb(1'b1, `SCC_ADR_CMR, 8'h0D);
    wb(1'b1, `SCC_ADR_MODE, 8'h38);
    wb(1'b1, `SCC_ADR_TDR, 8'h3F);
    wb(1'b1, `SCC_ADR_CTRL, 8'h21);
    xmit(1'b0);
    check(got, enc(8'h3F, 1'b1, 1'b1, 1'b1));
    check(got[8], 1'b1);
    // Error signal from the card forces a resend of the same character
    wb(1'b1, `SCC_ADR_TDR, 8'hC3);
    xmit(1'b1);
    check(got, enc(8'hC3, 1'b1, 1'b1, 1'b1));
    wb(1'b0, `SCC_ADR_STAT, 8'h00);
    check(q[4], 1'b1);
    // Receive with a parity error, then a clean character
    wb(1'b1, `SCC_ADR_CTRL, 8'h01);
    wb(1'b1, `SCC_ADR_STAT, 8'h00);
    wb(1'b1, `SCC_ADR_CMR, 8'h01);
    wb(1'b1, `SCC_ADR_MODE, 8'h28);
    wb(1'b1, `SCC_ADR_CTRL, 8'h11);
    scc_card_model_inst.give(enc(8'hA5, 1'b0, 1'b0, 1'b0) ^ 9'h100);
    scc_card_model_inst.wait_sck(372);
    check(line, 1'b0);
    scc_card_model_inst.wait_sck(744);
    wb(1'b0, `SCC_ADR_STAT, 8'h00);
    check(q[3], 1'b1);
    wb(1'b0, `SCC_ADR_RDR, 8'h00);
    check(q, 8'hA5);
    wb(1'b1, `SCC_ADR_STAT, 8'h00);
    scc_card_model_inst.give(enc(8'h3C, 1'b0, 1'b0, 1'b0));
    scc_card_model_inst.wait_sck(372);
    check(line, 1'b1);
    wb(1'b0, `SCC_ADR_RDR, 8'h00);
    check(q, 8'h3C);
    check(scc_card_model_inst.timeouts, 0);
    print_verdict;
  end
endmodule : scc_top_tb
